// >>> rtl/zol_map.svh
// offsets, field positions, reset values and limits of the repeat/loop block
`ifndef ZOL_MAP_SVH
`define ZOL_MAP_SVH

// register byte offsets
`define ZOL_CTRL_OFS        5'h00
`define ZOL_STATUS_OFS      5'h04
`define ZOL_ITER_COUNT_OFS  5'h08
`define ZOL_BODY_COUNT_OFS  5'h0C
`define ZOL_BODY_FIRST_OFS  5'h10
`define ZOL_BODY_LAST_OFS   5'h14

// control fields
`define ZOL_CTRL_ENABLE_BIT 0
`define ZOL_CTRL_CLEAR_BIT  1
`define ZOL_CTRL_RESET      1'h1

// status fields
`define ZOL_ST_ITER_BIT     0
`define ZOL_ST_BODY_BIT     1
`define ZOL_ST_PTR_LSB      2
`define ZOL_ST_OVF_BIT      8
`define ZOL_ST_UNF_BIT      9
`define ZOL_ST_RANGE_BIT    10

// limits
`define ZOL_COUNT_MAX       16'h7FFF
`define ZOL_COUNT_MIN       16'h0001
`define ZOL_BODY_LEN_MIN    8'h02
`define ZOL_BODY_LEN_MAX    8'hFF
`define ZOL_NEST_LEVELS     4
`define ZOL_PTR_TOP         3'h4

`endif

// >>> rtl/zol_pkg.sv
// types shared by the repeat/loop controller files
package zol_pkg;

   typedef struct packed {
      logic        use_gpr;
      logic [2:0]  gpr_idx;
      logic [15:0] imm;
   } count_src_type;

   typedef struct packed {
      logic [15:0] first;
      logic [15:0] last;
      logic [15:0] count;
   } nest_entry_type;

   typedef enum logic [1:0] {
      IT_IDLE = 2'b00,
      IT_DEAD = 2'b01,
      IT_RUN  = 2'b10
   } iterate_state_type;

   typedef struct packed {
      logic        iter_active;
      logic        body_active;
      logic [2:0]  nest_ptr;
      logic        overflow;
      logic        underflow;
      logic        range_err;
      logic [15:0] iter_count;
      logic [15:0] body_count;
      logic [15:0] body_first;
      logic [15:0] body_last;
   } status_type;

   typedef struct packed {
      logic enable;
      logic err_clear;
   } ctrl_type;

endpackage

// >>> rtl/nest_save_stack.sv
// four-level save file for first address, last address and pass count
`timescale 1ns/1ns
module nest_save_stack
   import zol_pkg::*;
#(
   parameter int LEVELS = 4
) (
   // clock
   input  wire logic                      sys_clk_in,
   // write port
   input  wire logic                      wr_en_in,
   input  wire logic [$clog2(LEVELS)-1:0] wr_idx_in,
   input  wire nest_entry_type            wr_data_in,
   // read port
   input  wire logic [$clog2(LEVELS)-1:0] rd_idx_in,
   output nest_entry_type                 rd_data_out
);

   nest_entry_type slot_ff [LEVELS];

   initial begin
      if (LEVELS < 2) begin
         $error("nest_save_stack needs at least two levels");
      end
   end

   // no reset: contents are only meaningful after a push
   always_ff @(posedge sys_clk_in) begin
      if (wr_en_in) begin
         slot_ff[wr_idx_in] <= wr_data_in;
      end
   end

   assign rd_data_out = slot_ff[rd_idx_in];

endmodule // nest_save_stack

// >>> rtl/zol_avalon_regs.sv
// avalon-mm slave holding control and showing controller state
`timescale 1ns/1ns
`include "zol_map.svh"
module zol_avalon_regs
   import zol_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        sys_rst_in,
   // avalon-mm slave
   input  wire logic [4:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   // block side
   input  wire status_type  status_in,
   output ctrl_type         ctrl_out
);

   logic        ack_ff;
   logic        enable_ff;
   logic        clear_ff;
   logic [31:0] readdata_ff;
   logic [31:0] nxt_readdata;
   logic        wr_take;

   // one wait state: every access ends on the second edge after it is raised
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_ff;
   // a write lands only on the edge that sees waitrequest low
   assign wr_take = avs_write_in & ack_ff;

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (avs_read_in | avs_write_in) & ~ack_ff;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         enable_ff <= `ZOL_CTRL_RESET;
         clear_ff  <= 1'b0;
      end else begin
         clear_ff <= 1'b0;
         if (wr_take && avs_address_in == `ZOL_CTRL_OFS
             && avs_byteenable_in[0]) begin
            enable_ff <= avs_writedata_in[`ZOL_CTRL_ENABLE_BIT];
            clear_ff  <= avs_writedata_in[`ZOL_CTRL_CLEAR_BIT];
         end
      end
   end

   always_comb begin
      nxt_readdata = 32'h0000_0000;
      unique case (avs_address_in)
         `ZOL_CTRL_OFS: begin
            nxt_readdata[`ZOL_CTRL_ENABLE_BIT] = enable_ff;
         end
         `ZOL_STATUS_OFS: begin
            nxt_readdata[`ZOL_ST_ITER_BIT] = status_in.iter_active;
            nxt_readdata[`ZOL_ST_BODY_BIT] = status_in.body_active;
            nxt_readdata[`ZOL_ST_PTR_LSB +: 3] = status_in.nest_ptr;
            nxt_readdata[`ZOL_ST_OVF_BIT] = status_in.overflow;
            nxt_readdata[`ZOL_ST_UNF_BIT] = status_in.underflow;
            nxt_readdata[`ZOL_ST_RANGE_BIT] = status_in.range_err;
         end
         `ZOL_ITER_COUNT_OFS: nxt_readdata[15:0] = status_in.iter_count;
         `ZOL_BODY_COUNT_OFS: nxt_readdata[15:0] = status_in.body_count;
         `ZOL_BODY_FIRST_OFS: nxt_readdata[15:0] = status_in.body_first;
         `ZOL_BODY_LAST_OFS:  nxt_readdata[15:0] = status_in.body_last;
         default:             nxt_readdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         readdata_ff <= 32'h0000_0000;
      end else if (avs_read_in && !ack_ff) begin
         readdata_ff <= nxt_readdata;
      end
   end

   assign avs_readdata_out = readdata_ff;
   assign ctrl_out.enable = enable_ff;
   assign ctrl_out.err_clear = clear_ff;

endmodule // zol_avalon_regs

// >>> rtl/zero_overhead_repeat_loop_control.sv
// zero-overhead single-op repeat and nested block loop controller
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`include "zol_map.svh"
module zero_overhead_repeat_loop_control
   import zol_pkg::*;
#(
   parameter int LEVELS = `ZOL_NEST_LEVELS
) (
   // clock and reset
   input  wire logic             sys_clk_in,
   input  wire logic             sys_rst_in,
   // avalon-mm register slave
   input  wire logic [4:0]       avs_address_in,
   input  wire logic             avs_read_in,
   input  wire logic             avs_write_in,
   input  wire logic [31:0]      avs_writedata_in,
   input  wire logic [3:0]       avs_byteenable_in,
   output logic [31:0]           avs_readdata_out,
   output logic                  avs_waitrequest_out,
   // decode stage commands
   input  wire logic             iterate_instr_in,
   input  wire logic             body_instr_in,
   input  wire logic             nest_discard_instr_in,
   input  wire count_src_type    count_src_in,
   input  wire logic [15:0]      body_first_in,
   input  wire logic [7:0]       body_len_in,
   input  wire logic [7:0][15:0] gpr_low_halves_in,
   // fetch and execute progress
   input  wire logic             iterated_exec_in,
   input  wire logic             fetch_valid_in,
   input  wire logic [15:0]      fetch_pc_in,
   // program counter steering
   output logic                  pc_hold_out,
   output logic                  pc_load_out,
   output logic [15:0]           pc_target_out,
   output logic                  irq_block_out,
   // state flags
   output logic                  iterate_active_flag_out,
   output logic                  body_active_flag_out
);

   initial begin
      if (LEVELS != `ZOL_NEST_LEVELS) begin
         $error("pointer width serves exactly four nesting levels");
      end
      if (`ZOL_PTR_TOP != 3'(LEVELS)) begin
         $error("stack top code must match the nesting depth");
      end
      if (`ZOL_COUNT_MIN > `ZOL_COUNT_MAX) begin
         $error("count limits are reversed");
      end
      if (`ZOL_BODY_LEN_MIN < 8'h02) begin
         $error("a body shorter than two ops cannot loop");
      end
   end

   // picks the count operand from a general register or the immediate
   function automatic logic [15:0] pick_count(input count_src_type src,
                                              input logic [7:0][15:0] gpr);
      logic [15:0] raw;
      raw = src.use_gpr ? gpr[src.gpr_idx] : src.imm;
      return raw;
   endfunction

   // out-of-range counts are pinned to the nearest legal value
   function automatic logic [15:0] clamp_count(input logic [15:0] raw);
      logic [15:0] res;
      res = raw;
      if (raw < `ZOL_COUNT_MIN) begin
         res = `ZOL_COUNT_MIN;
      end else if (raw > `ZOL_COUNT_MAX) begin
         res = `ZOL_COUNT_MAX;
      end
      return res;
   endfunction

   function automatic logic count_bad(input logic [15:0] raw);
      return (raw < `ZOL_COUNT_MIN) || (raw > `ZOL_COUNT_MAX);
   endfunction

   ctrl_type          ctrl;
   status_type        status;
   iterate_state_type iter_state_ff;
   logic [15:0]       iteration_counter_ff;
   logic [15:0]       body_pass_counter_ff;
   logic [15:0]       body_first_addr_ff;
   logic [15:0]       body_last_addr_ff;
   logic [2:0]        nest_ptr_ff;
   logic              body_active_ff;
   logic              overflow_ff;
   logic              underflow_ff;
   logic              range_err_ff;

   logic              iter_go;
   logic              iter_last;
   logic              iter_start;
   logic              body_go;
   logic              discard_go;
   logic              end_hit;
   logic              end_final;
   logic              pop;
   logic              pop_ok;
   logic              push_ok;
   logic              start_go;
   logic [15:0]       op_count;
   logic              op_bad;
   logic              len_bad;
   nest_entry_type    push_entry;
   nest_entry_type    pop_entry;

   // commands are ignored while software has the controller disabled
   assign iter_go    = iterate_instr_in & ctrl.enable;
   assign body_go    = body_instr_in & ctrl.enable;
   assign discard_go = nest_discard_instr_in & ctrl.enable;

   assign op_count = pick_count(count_src_in, gpr_low_halves_in);
   assign op_bad   = count_bad(op_count);
   assign len_bad  = (body_len_in < `ZOL_BODY_LEN_MIN);

   // ---------------- single-op repeat ----------------

   assign iter_last = (iter_state_ff == IT_RUN) && iterated_exec_in
                      && (iteration_counter_ff == 16'h0001);
   // a repeat command while one is running is ignored
   assign iter_start = (iter_state_ff == IT_IDLE) && iter_go;

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         iter_state_ff <= IT_IDLE;
      end else begin
         unique case (iter_state_ff)
            IT_IDLE: begin
               if (iter_go) begin
                  iter_state_ff <= IT_DEAD;
               end
            end
            IT_DEAD: begin
               iter_state_ff <= IT_RUN;
            end
            IT_RUN: begin
               if (iter_last) begin
                  iter_state_ff <= IT_IDLE;
               end
            end
            default: begin
               iter_state_ff <= IT_IDLE;
            end
         endcase
      end
   end

   // only the repeat counter is touched here, never the stack
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         iteration_counter_ff <= 16'h0000;
      end else if (iter_start) begin
         iteration_counter_ff <= clamp_count(op_count);
      end else if (iter_state_ff == IT_RUN && iterated_exec_in) begin
         iteration_counter_ff <= iteration_counter_ff - 16'h0001;
      end
   end

   // the issue cycle advances the counter; it then stays frozen on the
   // address after the repeated instruction until the final execution
   assign pc_hold_out = (iter_state_ff != IT_IDLE)
                        && !iter_last;
   // the issue cycle blocks too, so no acknowledge slips in before it
   assign irq_block_out = iter_go
                          || (iter_state_ff != IT_IDLE);
   assign iterate_active_flag_out = (iter_state_ff != IT_IDLE);

   // ---------------- block loops ----------------

   // last-address match is ignored while a single op repeats in place
   assign end_hit = body_active_ff && fetch_valid_in && !pc_hold_out
                    && (fetch_pc_in == body_last_addr_ff);
   // the count before the decrement decides the final pass
   assign end_final = end_hit && (body_pass_counter_ff == 16'h0001);
   assign pop = end_final || (discard_go && !end_hit);
   // pops above the top only move the pointer: no slot holds them
   assign pop_ok = pop && (nest_ptr_ff != 3'h0)
                   && (nest_ptr_ff <= `ZOL_PTR_TOP);
   // a start coinciding with a last-address hit or a discard is dropped,
   // so one edge never both pushes and pops
   assign start_go = body_go && !end_hit && !discard_go;
   assign push_ok  = start_go && (nest_ptr_ff < `ZOL_PTR_TOP);

   assign pc_load_out = end_hit && !end_final;
   assign pc_target_out = body_first_addr_ff;

   assign push_entry.first = body_first_addr_ff;
   assign push_entry.last  = body_last_addr_ff;
   assign push_entry.count = body_pass_counter_ff;

   // slot n lives at index n-1 of the save file
   nest_save_stack #(
      .LEVELS (LEVELS)
   ) u_nest_save_stack (
      .sys_clk_in  (sys_clk_in),
      .wr_en_in    (push_ok),
      .wr_idx_in   (nest_ptr_ff[1:0]),
      .wr_data_in  (push_entry),
      .rd_idx_in   (2'(nest_ptr_ff - 3'h1)),
      .rd_data_out (pop_entry)
   );

   // addresses change only on push and pop; a last-address hit keeps them
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         body_first_addr_ff <= 16'h0000;
         body_last_addr_ff  <= 16'h0000;
      end else if (pop_ok) begin
         body_first_addr_ff <= pop_entry.first;
         body_last_addr_ff  <= pop_entry.last;
      end else if (push_ok) begin
         body_first_addr_ff <= body_first_in;
         body_last_addr_ff  <= body_first_in + {8'h00, body_len_in}
                               - 16'h0001;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         body_pass_counter_ff <= 16'h0000;
      end else if (pop_ok) begin
         body_pass_counter_ff <= pop_entry.count;
      end else if (end_hit) begin
         body_pass_counter_ff <= body_pass_counter_ff - 16'h0001;
      end else if (push_ok) begin
         body_pass_counter_ff <= clamp_count(op_count);
      end
   end

   // post-increment on start, pre-decrement on end or discard
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         nest_ptr_ff <= 3'h0;
      end else if (pop && nest_ptr_ff != 3'h0) begin
         nest_ptr_ff <= nest_ptr_ff - 3'h1;
      end else if (start_go && nest_ptr_ff != 3'h7) begin
         // saturates at seven so runaway starts never wrap to zero
         nest_ptr_ff <= nest_ptr_ff + 3'h1;
      end
   end

   // only the pop of the outermost level clears it
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         body_active_ff <= 1'b0;
      end else if (pop && nest_ptr_ff == 3'h1) begin
         body_active_ff <= 1'b0;
      end else if (push_ok) begin
         body_active_ff <= 1'b1;
      end
   end

   assign body_active_flag_out = body_active_ff;

   // sticky errors: a new error in the clearing cycle still sets the bit
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         overflow_ff <= 1'b0;
      end else begin
         overflow_ff <= (overflow_ff && !ctrl.err_clear)
                        || (start_go
                            && nest_ptr_ff >= `ZOL_PTR_TOP);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         underflow_ff <= 1'b0;
      end else begin
         underflow_ff <= (underflow_ff && !ctrl.err_clear)
                         || (pop && nest_ptr_ff == 3'h0);
      end
   end

   // a bad count still runs, clamped, so software must read the flag
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         range_err_ff <= 1'b0;
      end else begin
         range_err_ff <= (range_err_ff && !ctrl.err_clear)
                         || ((iter_go || body_go) && op_bad)
                         || (body_go && len_bad);
      end
   end

   // ---------------- register slave ----------------

   assign status.iter_active = iterate_active_flag_out;
   assign status.body_active = body_active_ff;
   assign status.nest_ptr    = nest_ptr_ff;
   assign status.overflow    = overflow_ff;
   assign status.underflow   = underflow_ff;
   assign status.range_err   = range_err_ff;
   assign status.iter_count  = iteration_counter_ff;
   assign status.body_count  = body_pass_counter_ff;
   assign status.body_first  = body_first_addr_ff;
   assign status.body_last   = body_last_addr_ff;

   zol_avalon_regs u_regs (
      .sys_clk_in          (sys_clk_in),
      .sys_rst_in          (sys_rst_in),
      .avs_address_in      (avs_address_in),
      .avs_read_in         (avs_read_in),
      .avs_write_in        (avs_write_in),
      .avs_writedata_in    (avs_writedata_in),
      .avs_byteenable_in   (avs_byteenable_in),
      .avs_readdata_out    (avs_readdata_out),
      .avs_waitrequest_out (avs_waitrequest_out),
      .status_in           (status),
      .ctrl_out            (ctrl)
   );

endmodule // zero_overhead_repeat_loop_control

// >>> verification/zol_chk.sv
// port-level assertions for the repeat/loop controller
`timescale 1ns/1ns
module zol_chk (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // decode and fetch
   input wire logic iterate_instr_in,
   input wire logic body_instr_in,
   input wire logic nest_discard_instr_in,
   input wire logic fetch_valid_in,
   // steering and flags
   input wire logic pc_hold_out,
   input wire logic pc_load_out,
   input wire logic irq_block_out,
   input wire logic iterate_active_flag_out,
   input wire logic body_active_flag_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);

   a_iter_cause: assert property ($rose(iterate_active_flag_out) |->
      $past(iterate_instr_in)) else $error("repeat began without command");
   a_irq_early: assert property ($rose(iterate_active_flag_out) |->
      $past(irq_block_out)) else $error("irq not blocked at command");
   a_irq_span: assert property (iterate_active_flag_out |->
      irq_block_out) else $error("irq open during repeat");
   a_dead_hold: assert property ($rose(iterate_active_flag_out) |->
      pc_hold_out) else $error("pc not frozen in dead cycle");
   a_exit_free: assert property ($fell(iterate_active_flag_out) |->
      !pc_hold_out) else $error("pc still frozen after repeat");
   a_hold_owner: assert property (pc_hold_out |->
      iterate_active_flag_out && !pc_load_out)
      else $error("hold outside repeat or with load");
   a_body_cause: assert property ($rose(body_active_flag_out) |->
      $past(body_instr_in)) else $error("block began without command");
   a_load_cause: assert property (pc_load_out |->
      fetch_valid_in && body_active_flag_out)
      else $error("pc load outside an active block");
   a_discard_pc: assert property (nest_discard_instr_in |->
      !pc_load_out) else $error("discard moved the pc");
   a_rst_clear: assert property (disable iff (1'b0) sys_rst_in |=>
      !iterate_active_flag_out && !body_active_flag_out && !pc_hold_out)
      else $error("flags not cleared by reset");
endmodule // zol_chk

bind zero_overhead_repeat_loop_control zol_chk i_chk (
   .sys_clk_in, .sys_rst_in, .iterate_instr_in, .body_instr_in,
   .nest_discard_instr_in, .fetch_valid_in, .pc_hold_out, .pc_load_out,
   .irq_block_out, .iterate_active_flag_out, .body_active_flag_out);

// >>> verification/fetch_model.sv
// fetch unit model that follows the controller's pc steering
`timescale 1ns/1ns
module fetch_model (
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        sys_rst_in,
   // steering from the controller
   input  wire logic        pc_hold_in,
   input  wire logic        pc_load_in,
   input  wire logic [15:0] pc_target_in,
   input  wire logic        iter_flag_in,
   input  wire logic        slow_in,
   // fetch progress
   output logic             fetch_valid_out,
   output logic [15:0]      fetch_pc_out,
   output logic             iterated_exec_out
);
   logic [15:0] pc_ff;
   logic        gap_ff;
   logic        flag_ff;
   assign fetch_valid_out = !gap_ff;
   // empty slots show the inverse so a stale address never looks valid
   assign fetch_pc_out = gap_ff ? ~pc_ff : pc_ff;
   // the one repeated op runs in each fetched slot after the dead cycle
   assign iterated_exec_out = iter_flag_in & flag_ff & !gap_ff;
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         gap_ff  <= 1'b0;
         flag_ff <= 1'b0;
         pc_ff   <= 16'h0000;
      end else begin
         gap_ff  <= slow_in & !gap_ff;
         flag_ff <= iter_flag_in;
         if (!gap_ff && pc_load_in) begin
            pc_ff <= pc_target_in;
         end else if (!gap_ff && !pc_hold_in) begin
            pc_ff <= pc_ff + 16'h0001;
         end
      end
   end
endmodule // fetch_model

// >>> verification/tb_top.sv
// self-checking bench for the repeat/loop controller
`timescale 1ns/1ns
`include "zol_map.svh"
module tb_top;
   import zol_pkg::*;
   typedef struct {
      bit            body;
      count_src_type src;
      logic [7:0]    len;
      int            exp;
   } row_type;
   logic             clk, rst, rd, wr, wreq, it_p, bd_p, dc_p, slow;
   logic             exec, fv, hold, load, irq, it_f, bd_f;
   logic [4:0]       adr;
   logic [31:0]      wd, rdata, q;
   count_src_type    src;
   logic [15:0]      first, fpc, tgt, p;
   logic [7:0]       len;
   logic [7:0][15:0] gpr;
   int               failures, samples_checked, execs, loads;
   row_type          rows[9];

   zero_overhead_repeat_loop_control i_dut (
      .sys_clk_in(clk), .sys_rst_in(rst), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wreq), .iterate_instr_in(it_p),
      .body_instr_in(bd_p), .nest_discard_instr_in(dc_p),
      .count_src_in(src), .body_first_in(first), .body_len_in(len),
      .gpr_low_halves_in(gpr), .iterated_exec_in(exec),
      .fetch_valid_in(fv), .fetch_pc_in(fpc), .pc_hold_out(hold),
      .pc_load_out(load), .pc_target_out(tgt), .irq_block_out(irq),
      .iterate_active_flag_out(it_f), .body_active_flag_out(bd_f));

   fetch_model i_fetch (
      .sys_clk_in(clk), .sys_rst_in(rst), .pc_hold_in(hold),
      .pc_load_in(load), .pc_target_in(tgt), .iter_flag_in(it_f),
      .slow_in(slow), .fetch_valid_out(fv), .fetch_pc_out(fpc),
      .iterated_exec_out(exec));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      if (exec === 1'b1) execs <= execs + 1;
      if (load === 1'b1) loads <= loads + 1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [31:0] d);
      int n;
      adr <= a;
      wr  <= w;
      rd  <= !w;
      wd  <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      chk({31'h0, wreq}, 32'h0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic run_row(input row_type r);
      int e0, l0, n;
      src   <= r.src;
      first <= (fv ? fpc : ~fpc) + 16'h0003;
      len   <= r.len;
      if (r.body) bd_p <= 1'b1;
      else it_p <= 1'b1;
      @(posedge clk);
      bd_p <= 1'b0;
      it_p <= 1'b0;
      e0 = execs;
      l0 = loads;
      n = 0;
      @(posedge clk);
      if (!r.body) chk(irq, 32'h1);
      while ((it_f | bd_f) !== 1'b0 && n < 40000) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, it_f | bd_f}, 32'h0);
      if (r.body) chk(loads - l0, r.exp);
      else chk(execs - e0, r.exp);
      $display("row done at %0t", $time);
   endtask

   task complete_run;
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge clk);
      failures++;
      $display("unexpected at %0t: watchdog expired", $time);
      complete_run;
   end

   initial begin
      rst = 1'b1; rd = 1'b0; wr = 1'b0; adr = 5'h00; wd = 32'h0;
      it_p = 1'b0; bd_p = 1'b0; dc_p = 1'b0; slow = 1'b0; src = '0;
      first = 16'h0000; len = 8'h00; execs = 0; loads = 0;
      for (int i = 0; i < 8; i++) gpr[i] = 16'(i + 1);
      // counts stay in range and bodies hold 2 to 255 ops
      rows = '{'{0, '{1'b0, 3'h0, 16'h0001}, 8'h00, 1},
               '{0, '{1'b0, 3'h0, 16'h0003}, 8'h00, 3},
               '{0, '{1'b1, 3'h5, 16'h0000}, 8'h00, 6},
               '{0, '{1'b1, 3'h7, 16'h0000}, 8'h00, 8},
               '{0, '{1'b0, 3'h0, 16'h7FFF}, 8'h00, 32767},
               '{1, '{1'b0, 3'h0, 16'h0002}, 8'h02, 1},
               '{1, '{1'b0, 3'h0, 16'h0003}, 8'hFF, 2},
               '{1, '{1'b0, 3'h0, 16'h0001}, 8'h05, 0},
               '{1, '{1'b1, 3'h2, 16'h0000}, 8'h04, 2}};
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) run_row(rows[i]);
      slow <= 1'b1;
      run_row('{1, '{1'b0, 3'h0, 16'h0003}, 8'h02, 2});
      slow <= 1'b0;
      bus(1'b0, `ZOL_ITER_COUNT_OFS, 32'h0);
      chk(q, 32'h0);
      run_row('{0, '{1'b0, 3'h0, 16'h0000}, 8'h00, 1});
      bus(1'b0, `ZOL_STATUS_OFS, 32'h0);
      chk(q & 32'h400, 32'h400);
      bus(1'b1, `ZOL_CTRL_OFS, 32'h3);
      bus(1'b0, `ZOL_STATUS_OFS, 32'h0);
      chk(q, 32'h0);
      // five starts on far bodies: fifth one overflows
      for (int i = 0; i < 5; i++) begin
         first <= fpc + 16'h0400;
         len   <= 8'h0A;
         src   <= '{1'b0, 3'h0, 16'h0005};
         bd_p  <= 1'b1;
         @(posedge clk);
         bd_p  <= 1'b0;
         @(posedge clk);
      end
      bus(1'b0, `ZOL_STATUS_OFS, 32'h0);
      chk(q, 32'h116);
      for (int i = 0; i < 5; i++) begin
         p = fpc;
         dc_p <= 1'b1;
         @(posedge clk);
         dc_p <= 1'b0;
         @(posedge clk);
         chk(fpc, p + 16'h0002);
      end
      bus(1'b0, `ZOL_STATUS_OFS, 32'h0);
      chk(q, 32'h100);
      dc_p <= 1'b1;
      @(posedge clk);
      dc_p <= 1'b0;
      @(posedge clk);
      bus(1'b0, `ZOL_STATUS_OFS, 32'h0);
      chk(q & 32'h200, 32'h200);
      $display("nesting done at %0t", $time);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, `ZOL_CTRL_OFS, 32'h0);
      chk(q, 32'h1);
      bus(1'b0, `ZOL_STATUS_OFS, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 5'h18, 32'h0);
      chk(q, 32'h0);
      // disabled controller ignores both commands
      bus(1'b1, `ZOL_CTRL_OFS, 32'h0);
      it_p <= 1'b1;
      bd_p <= 1'b1;
      @(posedge clk);
      it_p <= 1'b0;
      bd_p <= 1'b0;
      chk(irq, 32'h0);
      bus(1'b0, `ZOL_STATUS_OFS, 32'h0);
      chk(q, 32'h0);
      $display("reset done at %0t", $time);
      complete_run;
   end
endmodule // tb_top
